/* File: lsm_pkg.sv */
// shared constants for the line signal loss monitor
package lsm_pkg;
  // status bit positions
  localparam int STAT_BIT_COMBINED = 1;
  localparam int STAT_BIT_ANALOG = 4;
  localparam int STAT_BIT_DIGITAL = 5;
  localparam int STAT_WIDTH = 8;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // digital detector timing in bit periods; clear density in percent
  localparam int ABSENT_DECLARE_BITS = 160;
  localparam int DENSITY_WINDOW_BITS = 24;
  localparam int DENSITY_PERCENT = 33;
  // line rate modes
  typedef enum logic [1:0] {
    LSM_MODE_DS3 = 2'b00,
    LSM_MODE_STS1 = 2'b01,
    LSM_MODE_E3 = 2'b10
  } lsm_mode_type;
endpackage : lsm_pkg

/* File: lsm_monitor.sv */
// per-channel signal loss monitor: digital, analog and combined flags
// How it works
// - declare digital loss after 160 pulseless bits, in DS3 and STS-1 modes only
// - clear digital loss at density of 33 percent
// - digital flag on status bit 5, reset 0
// - analog flag set below declare threshold
// - analog flag clears only above clear threshold, or outside DS3 and STS-1 modes
// - analog flag on status bit 4, reset 0
// - combined loss is digital OR analog in DS3 and STS-1 modes
// - combined loss on status bit 1
// - E3 mode uses the G.775 detector input
`timescale 1ns/1ps
module lsm_monitor
  import lsm_pkg::*;
#(
  parameter int ABSENT_BITS = ABSENT_DECLARE_BITS,
  parameter int WINDOW_BITS = DENSITY_WINDOW_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // line side, from the recovery path
  input wire logic bit_en_i,
  input wire logic pulse_i,
  input wire logic amp_below_declare_i,
  input wire logic amp_above_clear_i,
  input wire logic g775_loss_i,
  input wire lsm_mode_type mode_i,
  // status
  output logic [STAT_WIDTH-1:0] status_o,
  output logic signal_loss_o
);

  localparam int CW = $clog2(ABSENT_BITS + 1);
  localparam int WW = $clog2(WINDOW_BITS + 1);
  localparam logic [WW-1:0] DENSITY_NEED = WW'((WINDOW_BITS * DENSITY_PERCENT + 99) / 100);

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] clr_sync;
    logic [CW-1:0] absent_cnt;
    logic [WINDOW_BITS-1:0] window;
    logic [WW-1:0] ones;
    logic digital;
    logic analog;
    logic [STAT_WIDTH-1:0] status;
    logic loss;
  } lsm_state_type;

  lsm_state_type state;
  lsm_state_type next_state;

  function automatic logic is_ds3_like(input lsm_mode_type m);
    return (m == LSM_MODE_DS3) || (m == LSM_MODE_STS1);
  endfunction

  // running ones count after one bit enters and the oldest leaves
  function automatic logic [WW-1:0] ones_next(input logic [WW-1:0] ones, input logic add, input logic drop);
    return ones + WW'(add) - WW'(drop);
  endfunction

  always_comb begin
    logic pulse;
    logic combined;
    next_state = state;
    pulse = state.pin_sync[1];
    combined = 1'b0;
    // analog comparators are asynchronous to clk; two flops before use
    next_state.pin_sync = {state.pin_sync[0], amp_below_declare_i};
    next_state.clr_sync = {state.clr_sync[0], amp_above_clear_i};
    if (bit_en_i) begin
      if (pulse_i) begin
        next_state.absent_cnt = '0;
      end else if (state.absent_cnt != CW'(ABSENT_BITS)) begin
        next_state.absent_cnt = state.absent_cnt + CW'(1);
      end
      next_state.window = {state.window[WINDOW_BITS-2:0], pulse_i};
      next_state.ones = ones_next(state.ones, pulse_i, state.window[WINDOW_BITS-1]);
      if (is_ds3_like(mode_i)) begin
        if (!pulse_i && state.absent_cnt == CW'(ABSENT_BITS - 1)) begin
          next_state.digital = 1'b1;
        // clear on enough density
        // density counts the bit just taken, else clearing lags a bit
        end else if (state.digital && next_state.ones >= DENSITY_NEED) begin
          next_state.digital = 1'b0;
        end
      end else begin
        next_state.digital = 1'b0;
      end
    end
    if (!is_ds3_like(mode_i)) begin
      next_state.analog = 1'b0;
    end else if (pulse) begin
      next_state.analog = 1'b1;
    end else if (state.clr_sync[1]) begin
      next_state.analog = 1'b0;
    end
    if (mode_i == LSM_MODE_E3) begin
      combined = g775_loss_i;
    end else begin
      combined = state.digital | state.analog;
    end
    next_state.loss = combined;
    // bit 5; bit 4; bit 1
    next_state.status = STAT_RESET;
    next_state.status[STAT_BIT_DIGITAL] = state.digital;
    next_state.status[STAT_BIT_ANALOG] = state.analog;
    next_state.status[STAT_BIT_COMBINED] = combined;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign status_o = state.status;
  assign signal_loss_o = state.loss;

  sequence absent_run_s;
    bit_en_i && !pulse_i && state.absent_cnt == CW'(ABSENT_BITS - 1) && is_ds3_like(mode_i);
  endsequence

  absent_declare_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    absent_run_s |=> state.digital ##1 status_o[STAT_BIT_DIGITAL])
    else $error("digital loss not declared after absent run");

  density_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_en_i && !(!pulse_i && state.absent_cnt == CW'(ABSENT_BITS - 1)) && state.digital
    && ones_next(state.ones, pulse_i, state.window[WINDOW_BITS-1]) >= DENSITY_NEED
    && is_ds3_like(mode_i) |=> !state.digital)
    else $error("digital loss not cleared at density");

  digital_stat_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 status_o[STAT_BIT_DIGITAL] == $past(state.digital))
    else $error("status bit 5 wrong");

  analog_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state.pin_sync[1] && is_ds3_like(mode_i) |=> state.analog)
    else $error("analog loss not declared");

  analog_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state.analog && !state.clr_sync[1] && is_ds3_like(mode_i) |=> state.analog)
    else $error("analog loss cleared without clear level");

  analog_stat_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 status_o[STAT_BIT_ANALOG] == $past(state.analog))
    else $error("status bit 4 wrong");

  combined_or_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode_i != LSM_MODE_E3 |=> signal_loss_o == ($past(state.digital) | $past(state.analog)))
    else $error("combined loss is not OR of detectors");

  combined_stat_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    status_o[STAT_BIT_COMBINED] == signal_loss_o)
    else $error("status bit 1 disagrees with combined loss");

  e3_path_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode_i == LSM_MODE_E3 |=> signal_loss_o == $past(g775_loss_i))
    else $error("E3 loss not from G.775 input");

  pulse_restart_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_en_i && pulse_i |=> state.absent_cnt == '0)
    else $error("absent count not restarted by pulse");

  // only the absent run may raise the digital flag
  absent_early_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !state.digital && !(bit_en_i && !pulse_i && state.absent_cnt == CW'(ABSENT_BITS - 1)) |=> !state.digital)
    else $error("digital loss declared early");

  digital_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state.digital && is_ds3_like(mode_i)
    && !(bit_en_i && ones_next(state.ones, pulse_i, state.window[WINDOW_BITS-1]) >= DENSITY_NEED)
    |=> state.digital)
    else $error("digital loss cleared without density");

  ones_count_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state.ones == WW'($countones(state.window)))
    else $error("density count disagrees with window");

  digital_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_en_i && !is_ds3_like(mode_i) |=> !state.digital)
    else $error("digital loss active outside DS3 and STS-1");

  analog_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !is_ds3_like(mode_i) |=> !state.analog)
    else $error("analog loss active outside DS3 and STS-1");

  analog_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !state.analog && !state.pin_sync[1] |=> !state.analog)
    else $error("analog loss declared without low amplitude");

  analog_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state.analog && state.clr_sync[1] && !state.pin_sync[1] |=> !state.analog)
    else $error("analog loss not cleared at clear level");

  // comparators are read only after two flops, never straight
  sync_stage_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> state.pin_sync[1] == $past(state.pin_sync[0]) && state.clr_sync[1] == $past(state.clr_sync[0]))
    else $error("comparator synchroniser skipped a stage");

  window_shift_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_en_i |=> state.window[0] == $past(pulse_i))
    else $error("density window missed a bit");

  absent_count_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_en_i && !pulse_i && state.absent_cnt != CW'(ABSENT_BITS) |=> state.absent_cnt == $past(state.absent_cnt) + CW'(1))
    else $error("absent count did not advance");

  // count holds between bit strobes, so it moves only when a bit is taken
  count_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !bit_en_i |=> $stable(state.absent_cnt))
    else $error("absent count moved without a bit");

  status_spare_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    status_o[7:6] == 2'h0 && status_o[3:2] == 2'h0 && !status_o[0])
    else $error("unused status bits not zero");

  // reset must clear every flag, even mid outage
  reset_clear_a: assert property (@(posedge clk_i)
    !nrst_i |=> status_o == STAT_RESET && !signal_loss_o)
    else $error("flags not cleared by reset");

endmodule // lsm_monitor

/* File: lsm_line_model.sv */
// line receiver model: bit strobes and pulses
`timescale 1ns/1ps
module lsm_line_model (
  // control
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic lvl_i,
  input wire logic slow_i,
  // line side
  output logic bit_en_o,
  output logic pulse_o
);
  logic ph = 1'b0;
  initial bit_en_o = 1'b0;
  initial pulse_o = 1'b0;
  // outside a bit the data line toggles, so a stale value never looks valid
  always @(negedge clk_i) begin
    ph <= slow_i ? ~ph : 1'b1;
    bit_en_o <= go_i & (ph | ~slow_i);
    pulse_o <= (go_i & (ph | ~slow_i)) ? lvl_i : ~pulse_o;
  end
endmodule // lsm_line_model

/* File: test_lsm_monitor.sv */
// self-checking bench for the signal loss monitor
`timescale 1ns/1ps
module test_lsm_monitor;
  import lsm_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, go = 1'b0, lvl = 1'b0, slow = 1'b0;
  logic bit_en_i, pulse_i, amp_b = 1'b0, amp_c = 1'b0, g775 = 1'b0, sl;
  lsm_mode_type mode = LSM_MODE_DS3;
  logic [7:0] st;
  int err_count = 0, checked = 0, seed = 14, k, n;
  logic g;
  lsm_line_model i_lsm_line_model (.clk_i(clk_i), .go_i(go), .lvl_i(lvl), .slow_i(slow),
    .bit_en_o(bit_en_i), .pulse_o(pulse_i));
  lsm_monitor i_lsm_monitor (.clk_i(clk_i), .nrst_i(nrst_i), .bit_en_i(bit_en_i), .pulse_i(pulse_i),
    .amp_below_declare_i(amp_b), .amp_above_clear_i(amp_c), .g775_loss_i(g775), .mode_i(mode),
    .status_o(st), .signal_loss_o(sl));
  initial forever #5 clk_i = ~clk_i;
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %b seen %b", nm, exp, seen);
      err_count++;
    end
  endtask
  // cnt bit periods at pulse level p, then a few settle cycles
  task automatic bits(input int cnt, input logic p);
    k = 0;
    n = 0;
    @(posedge clk_i) go <= 1'b1;
    lvl <= p;
    while (k < cnt) begin
      @(posedge clk_i) if (bit_en_i === 1'b1) k++;
      if (k == cnt) go <= 1'b0;
      if (++n > 1000) begin
        err_count++;
        print_verdict();
      end
    end
    repeat (3) @(negedge clk_i);
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    chk("status after reset", st == STAT_RESET, 1'b1);
    nrst_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      mode = m ? LSM_MODE_STS1 : LSM_MODE_DS3;
      slow = m[0];
      // one pulse restarts the absent count left from the last run
      bits(1, 1'b1);
      bits(159, 1'b0);
      chk("digital early", st[STAT_BIT_DIGITAL], 1'b0);
      bits(1, 1'b0);
      chk("digital set", st[STAT_BIT_DIGITAL], 1'b1);
      chk("combined", st[STAT_BIT_COMBINED] & sl, 1'b1);
      bits(7, 1'b1);
      chk("digital held", st[STAT_BIT_DIGITAL], 1'b1);
      bits(1, 1'b1);
      chk("digital clear", st[STAT_BIT_DIGITAL] | sl, 1'b0);
      bits(150, 1'b0);
      bits(1, 1'b1);
      bits(150, 1'b0);
      chk("absent restart", st[STAT_BIT_DIGITAL], 1'b0);
      $display("digital test mode %0d done", m);
    end
    amp_b = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("analog set", st[STAT_BIT_ANALOG] & st[STAT_BIT_COMBINED] & sl, 1'b1);
    amp_b = 1'b0;
    repeat (6) @(negedge clk_i);
    chk("analog held", st[STAT_BIT_ANALOG], 1'b1);
    amp_c = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("analog clear", st[STAT_BIT_ANALOG] | sl, 1'b0);
    amp_c = 1'b0;
    $display("analog test done");
    mode = LSM_MODE_E3;
    amp_b = 1'b1;
    bits(170, 1'b0);
    chk("e3 detectors off", st[STAT_BIT_DIGITAL] | st[STAT_BIT_ANALOG], 1'b0);
    for (int i = 0; i < 40; i++) begin
      g = $random(seed);
      g775 = g;
      @(negedge clk_i);
      chk("e3 loss", sl, g);
    end
    $display("e3 test done");
    g775 = 1'b1;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("reset mid run", st == STAT_RESET && sl == 1'b0, 1'b1);
    nrst_i = 1'b1;
    $display("reset test done");
    print_verdict();
  end
endmodule // test_lsm_monitor
